// ===== ledi_cfg.svh
// constants for the led register port: offsets, fields, resets and timing
`ifndef LEDI_CFG_SVH
`define LEDI_CFG_SVH
// timing
`define LEDI_CLK_NS       5
`define LEDI_EN_FILT_NS   60000
`define LEDI_EN_HOLD_NS   70000
`define LEDI_SCL_QTR_NS   625
// serial bus
`define LEDI_SLV_ADDR     7'h45
`define LEDI_ACK_BIT      4'h8
// register-select byte
`define LEDI_AUTO_BIT     4
`define LEDI_IDX_W        4
`define LEDI_IDX_PLANE_A  4'h0
`define LEDI_IDX_PLANE_B  4'h1
`define LEDI_IDX_PLANE_C  4'h2
`define LEDI_IDX_TIME_LO  4'h3
`define LEDI_IDX_TIME_HI  4'h7
`define LEDI_IDX_MAXI     4'h8
`define LEDI_IDX_ONESHOT  4'h9
`define LEDI_IDX_INIT     4'ha
`define LEDI_NREGS        10
// register reset values
`define LEDI_RST_PLANE    8'h00
`define LEDI_RST_TIME     8'h44
`define LEDI_RST_MAXI     8'hff
`define LEDI_RST_ONESHOT  8'h0f
// output-mode codes {c,b,a}
`define LEDI_MODE_ON_MIN  3'h2
`define LEDI_NOUT         7
// host registers on the ahb side
`define LEDI_A_CMD        8'h00
`define LEDI_A_STAT       8'h04
`define LEDI_A_SADDR      8'h08
`define LEDI_CMD_D0_LSB   8
`define LEDI_CMD_D1_LSB   16
`define LEDI_CMD_NB_LSB   24
`define LEDI_CMD_RD_BIT   26
`define LEDI_CMD_EN_BIT   27
`define LEDI_ST_RD0_LSB   8
`define LEDI_ST_RD1_LSB   16
`endif

// ===== ledi_chk_asserts.sv
// concurrent checks on the two-wire link and the device status outputs
`include "ledi_cfg.svh"
`timescale 1ns/1ps
module ledi_chk #(
  parameter int EN_CYC = 40
) (
  // clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // link
  input wire logic                  scl_i,
  input wire logic                  sda_i,
  input wire logic                  sda_d_oe,
  input wire logic                  en_n,
  // device outputs
  input wire logic [`LEDI_NOUT-1:0] led_drive,
  input wire logic                  shutdown
);
  // ****************************************
  // helper: cycles the enable pin stayed low
  // ****************************************
  logic [15:0] low_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt <= '0;
    end else if (en_n) begin
      low_cnt <= '0;
    end else if (low_cnt != 16'hffff) begin
      low_cnt <= low_cnt + 16'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // assertions
  // ****************************************
  AST_EN_HOLD: assert property ($rose(en_n) |-> low_cnt >= EN_CYC)
    else $error("enable pin released too early");
  AST_EN_FILTER: assert property ($rose(shutdown) |-> low_cnt >= EN_CYC)
    else $error("shutdown entered before enable filter time");
  AST_SD_EXIT: assert property ($rose(en_n) |-> ##[1:6] !shutdown)
    else $error("shutdown held after enable went high");
  AST_SD_LEDS: assert property (shutdown |-> led_drive == '0)
    else $error("outputs driven during shutdown");
  AST_SD_SDA: assert property (shutdown |-> !sda_d_oe)
    else $error("device drives data line in shutdown");
  AST_SCL_HI_STABLE: assert property (scl_i && $past(scl_i) |-> $stable(sda_d_oe))
    else $error("device changed data line while clock high");
  AST_OE_ON_LOW: assert property ($rose(sda_d_oe) |-> !scl_i)
    else $error("device took data line while clock high");
  AST_STOP_QUIET: assert property (scl_i && $rose(sda_i) |=> !sda_d_oe [*8])
    else $error("device active after stop");
  cover property ($rose(shutdown));
  cover property (scl_i && $fell(sda_i));
  cover property ($rose(sda_d_oe));
endmodule

// ===== ledi_device.sv
// led driver register port: serial slave, register file, output modes
`include "ledi_cfg.svh"
`timescale 1ns/1ps
module ledi_device #(
  parameter int EN_CYC = (`LEDI_EN_FILT_NS + `LEDI_CLK_NS - 1) / `LEDI_CLK_NS
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // link
  ledi_if.device                    link,
  // led outputs and status
  output logic [`LEDI_NOUT-1:0]     led_drive,
  output logic                      shutdown
);
  import ledi_pkg::*;

  localparam int CW = $clog2(EN_CYC + 1);

  logic               scl_s;
  logic               sda_s;
  logic               en_s;
  logic               scl_p_r;
  logic               sda_p_r;
  logic [CW-1:0]      en_cnt_r;
  logic               shutdown_r;
  ledi_dev_st_t       st_r;
  ledi_kind_t         kind_r;
  logic [3:0]         bitc_r;
  logic [7:0]         sh_r;
  logic               rw_r;
  logic               sda_low_r;
  logic [7:0]         sel_r;
  logic [7:0]         regs_r [0:`LEDI_NREGS-1];
  logic [`LEDI_NOUT-1:0] led_r;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_c;
  logic               stop_c;
  logic               byte_done;
  logic               wr_en;
  logic [`LEDI_IDX_W-1:0] idx;
  logic [7:0]         rd_byte;

  // ****************************************
  // pin sampling
  // ****************************************
  ledi_sync #(
    .W   (3),
    .RST (3'h7)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({link.scl_i, link.sda_i, link.en_n}),
    .q       ({scl_s, sda_s, en_s})
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_r;
  assign scl_fall  = ~scl_s & scl_p_r;
  assign start_c   = scl_s & scl_p_r & sda_p_r & ~sda_s;
  assign stop_c    = scl_s & scl_p_r & ~sda_p_r & sda_s;
  assign byte_done = (st_r == LEDI_D_RX) && scl_fall && (bitc_r == `LEDI_ACK_BIT);
  assign wr_en     = byte_done && (kind_r == LEDI_K_DATA);
  assign idx       = sel_r[`LEDI_IDX_W-1:0];
  assign rd_byte   = (idx < `LEDI_IDX_INIT) ? regs_r[idx] : 8'h00;

  // ****************************************
  // enable filter and shutdown
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_cnt_r   <= '0;
      shutdown_r <= 1'b0;
    end else if (en_s) begin
      en_cnt_r   <= '0;
      shutdown_r <= 1'b0;
    end else if (en_cnt_r != CW'(EN_CYC)) begin
      en_cnt_r   <= en_cnt_r + 1'b1;
    end else begin
      shutdown_r <= 1'b1;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  function automatic logic [7:0] rst_val(input int i);
    if (i >= int'(`LEDI_IDX_TIME_LO) && i <= int'(`LEDI_IDX_TIME_HI))
      return `LEDI_RST_TIME;
    else if (i == int'(`LEDI_IDX_MAXI))
      return `LEDI_RST_MAXI;
    else if (i == int'(`LEDI_IDX_ONESHOT))
      return `LEDI_RST_ONESHOT;
    else
      return `LEDI_RST_PLANE;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `LEDI_NREGS; i++) begin
        regs_r[i] <= rst_val(i);
      end
    end else if (shutdown_r) begin
      for (int i = 0; i < `LEDI_NREGS; i++) begin
        regs_r[i] <= rst_val(i);
      end
    end else if (wr_en && idx < `LEDI_IDX_INIT) begin
      regs_r[idx] <= sh_r;
    end
  end

  // ****************************************
  // serial slave
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= LEDI_D_IDLE;
      kind_r    <= LEDI_K_ADDR;
      bitc_r    <= 4'h0;
      sh_r      <= 8'h00;
      rw_r      <= 1'b0;
      sda_low_r <= 1'b0;
      sel_r     <= 8'h00;
    end else if (shutdown_r) begin
      st_r      <= LEDI_D_IDLE;
      kind_r    <= LEDI_K_ADDR;
      bitc_r    <= 4'h0;
      rw_r      <= 1'b0;
      sda_low_r <= 1'b0;
      sel_r     <= 8'h00;
    end else if (start_c) begin
      st_r      <= LEDI_D_RX;
      kind_r    <= LEDI_K_ADDR;
      bitc_r    <= 4'h0;
      sda_low_r <= 1'b0;
    end else if (stop_c) begin
      st_r      <= LEDI_D_IDLE;
      sda_low_r <= 1'b0;
    end else begin
      case (st_r)
        LEDI_D_RX: begin
          if (scl_rise && bitc_r != `LEDI_ACK_BIT) begin
            sh_r   <= {sh_r[6:0], sda_s};
            bitc_r <= bitc_r + 4'h1;
          end else if (byte_done) begin
            bitc_r <= 4'h0;
            case (kind_r)
              LEDI_K_ADDR: begin
                if (sh_r[7:1] == `LEDI_SLV_ADDR) begin
                  rw_r      <= sh_r[0];
                  sda_low_r <= 1'b1;
                  st_r      <= LEDI_D_ACK;
                end else begin
                  st_r      <= LEDI_D_IDLE;
                end
              end
              LEDI_K_CMD: begin
                sel_r     <= sh_r;
                sda_low_r <= 1'b1;
                st_r      <= LEDI_D_ACK;
              end
              default: begin
                if (sel_r[`LEDI_AUTO_BIT]) begin
                  if (idx == `LEDI_IDX_INIT)
                    sel_r[`LEDI_IDX_W-1:0] <= `LEDI_IDX_PLANE_A;
                  else
                    sel_r[`LEDI_IDX_W-1:0] <= idx + 4'h1;
                end
                sda_low_r <= 1'b1;
                st_r      <= LEDI_D_ACK;
              end
            endcase
          end
        end
        LEDI_D_ACK: begin
          if (scl_fall) begin
            if (kind_r == LEDI_K_ADDR && rw_r) begin
              sh_r      <= rd_byte;
              sda_low_r <= ~rd_byte[7];
              st_r      <= LEDI_D_TX;
            end else begin
              sda_low_r <= 1'b0;
              kind_r    <= (kind_r == LEDI_K_ADDR) ? LEDI_K_CMD : LEDI_K_DATA;
              st_r      <= LEDI_D_RX;
            end
          end
        end
        LEDI_D_TX: begin
          if (scl_rise) begin
            bitc_r <= bitc_r + 4'h1;
          end else if (scl_fall) begin
            if (bitc_r == `LEDI_ACK_BIT) begin
              sda_low_r <= 1'b0;
              bitc_r    <= 4'h0;
              st_r      <= LEDI_D_TXACK;
            end else begin
              sh_r      <= {sh_r[6:0], 1'b0};
              sda_low_r <= ~sh_r[6];
            end
          end
        end
        LEDI_D_TXACK: begin
          if (scl_rise && sda_s) begin
            st_r <= LEDI_D_IDLE;
          end else if (scl_fall) begin
            sh_r      <= rd_byte;
            sda_low_r <= ~rd_byte[7];
            st_r      <= LEDI_D_TX;
          end
        end
        default: begin
          st_r      <= LEDI_D_IDLE;
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // output modes
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_r <= '0;
    end else if (shutdown_r || (!en_s && en_cnt_r == CW'(EN_CYC))) begin
      led_r <= '0;
    end else begin
      for (int n = 0; n < `LEDI_NOUT; n++) begin
        led_r[n] <= {regs_r[`LEDI_IDX_PLANE_C][n], regs_r[`LEDI_IDX_PLANE_B][n],
                     regs_r[`LEDI_IDX_PLANE_A][n]} >= `LEDI_MODE_ON_MIN;
      end
    end
  end

  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = sda_low_r;
  assign led_drive     = led_r;
  assign shutdown      = shutdown_r;
endmodule

// ===== ledi_host.sv
// bus master end: ahb-lite registers drive serial transfers and the enable pin
//
// Our own choices: the register offsets and the AHB-Lite register port.
`include "ledi_cfg.svh"
`timescale 1ns/1ps
module ledi_host #(
  parameter int QTR_CYC = `LEDI_SCL_QTR_NS / `LEDI_CLK_NS,
  parameter int EN_HOLD = (`LEDI_EN_HOLD_NS + `LEDI_CLK_NS - 1) / `LEDI_CLK_NS
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // link
  ledi_if.host             link
);
  import ledi_pkg::*;

  localparam int QW = $clog2(QTR_CYC + 1);
  localparam int EW = $clog2(EN_HOLD + 1);

  logic         ap_wr_r;
  logic [7:0]   ap_addr_r;
  logic [31:0]  hrdata_r;
  logic [31:0]  cmd_r;
  logic [6:0]   saddr_r;
  logic         go_r;
  logic         sda_s;
  logic [QW-1:0] tq_r;
  logic         tick;
  ledi_mst_st_t st_r;
  logic [1:0]   q_r;
  logic [3:0]   bitc_r;
  logic [2:0]   step_r;
  logic [7:0]   sh_r;
  logic         rx_r;
  logic         ackbad_r;
  logic         nack_r;
  logic [7:0]   rd0_r;
  logic [7:0]   rd1_r;
  logic [EW-1:0] en_cnt_r;
  logic         scl_low_r;
  logic         sda_low_r;
  logic         en_n_r;
  logic         busy;
  logic         rd;
  logic [2:0]   total;
  logic [2:0]   nxt;
  logic         last;

  // ****************************************
  // ahb-lite registers
  // ****************************************
  assign busy  = go_r | (st_r != LEDI_M_IDLE);
  assign rd    = cmd_r[`LEDI_CMD_RD_BIT];
  assign total = rd ? 3'd3 + {1'b0, cmd_r[`LEDI_CMD_NB_LSB +: 2]}
                    : 3'd2 + {1'b0, cmd_r[`LEDI_CMD_NB_LSB +: 2]};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else if (hready) begin
      ap_wr_r   <= hsel & htrans[1] & hwrite;
      ap_addr_r <= haddr[7:0];
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          `LEDI_A_CMD:   hrdata_r <= cmd_r;
          `LEDI_A_STAT:  hrdata_r <= {8'h00, rd1_r, rd0_r, 6'h00, nack_r, busy};
          `LEDI_A_SADDR: hrdata_r <= {25'h0, saddr_r};
          default:       hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r   <= 32'h0000_0000;
      saddr_r <= `LEDI_SLV_ADDR;
    end else if (ap_wr_r) begin
      if (ap_addr_r == `LEDI_A_CMD && !busy)
        cmd_r <= hwdata;
      if (ap_addr_r == `LEDI_A_SADDR)
        saddr_r <= hwdata[6:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      go_r <= 1'b0;
    else if (ap_wr_r && ap_addr_r == `LEDI_A_CMD && !busy)
      go_r <= 1'b1;
    else if (tick && st_r == LEDI_M_IDLE)
      go_r <= 1'b0;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // ****************************************
  // quarter-bit timer and sampling
  // ****************************************
  ledi_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (link.sda_i),
    .q       (sda_s)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tq_r <= '0;
    else if (tick)
      tq_r <= '0;
    else
      tq_r <= tq_r + 1'b1;
  end

  assign tick = (tq_r == QW'(QTR_CYC - 1));

  // ****************************************
  // transfer sequencer
  // ****************************************
  function automatic logic [7:0] byte_at(input logic [2:0] s);
    case (s)
      3'd0:    return {saddr_r, 1'b0};
      3'd1:    return {3'h0, cmd_r[`LEDI_AUTO_BIT:0]};
      3'd2:    return rd ? {saddr_r, 1'b1} : cmd_r[`LEDI_CMD_D0_LSB +: 8];
      3'd3:    return cmd_r[`LEDI_CMD_D1_LSB +: 8];
      default: return 8'h00;
    endcase
  endfunction

  assign nxt  = step_r + 3'd1;
  assign last = (nxt == total);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r     <= LEDI_M_IDLE;
      q_r      <= 2'd0;
      bitc_r   <= 4'h0;
      step_r   <= 3'd0;
      sh_r     <= 8'h00;
      rx_r     <= 1'b0;
      ackbad_r <= 1'b0;
      nack_r   <= 1'b0;
      rd0_r    <= 8'h00;
      rd1_r    <= 8'h00;
      en_cnt_r <= '0;
    end else if (st_r == LEDI_M_EN) begin
      en_cnt_r <= en_cnt_r + 1'b1;
      if (en_cnt_r == EW'(EN_HOLD - 1))
        st_r <= LEDI_M_IDLE;
    end else if (tick) begin
      q_r <= q_r + 2'd1;
      case (st_r)
        LEDI_M_IDLE: begin
          q_r <= 2'd0;
          if (go_r && cmd_r[`LEDI_CMD_EN_BIT]) begin
            en_cnt_r <= '0;
            st_r     <= LEDI_M_EN;
          end else if (go_r) begin
            st_r   <= LEDI_M_START;
            step_r <= 3'd0;
            sh_r   <= byte_at(3'd0);
            rx_r   <= 1'b0;
            nack_r <= 1'b0;
          end
        end
        LEDI_M_START: begin
          if (q_r == 2'd3) begin
            st_r   <= LEDI_M_BIT;
            bitc_r <= 4'h0;
          end
        end
        LEDI_M_BIT: begin
          if (q_r == 2'd2 && bitc_r != `LEDI_ACK_BIT && rx_r)
            sh_r <= {sh_r[6:0], sda_s};
          if (q_r == 2'd2 && bitc_r == `LEDI_ACK_BIT && !rx_r)
            ackbad_r <= sda_s;
          if (q_r == 2'd3 && bitc_r != `LEDI_ACK_BIT) begin
            bitc_r <= bitc_r + 4'h1;
            if (!rx_r)
              sh_r <= {sh_r[6:0], 1'b0};
          end else if (q_r == 2'd3) begin
            bitc_r <= 4'h0;
            step_r <= nxt;
            if (rx_r && step_r == 3'd3)
              rd0_r <= sh_r;
            else if (rx_r)
              rd1_r <= sh_r;
            if (!rx_r && ackbad_r) begin
              nack_r <= 1'b1;
              st_r   <= LEDI_M_STOP;
            end else if (last) begin
              st_r <= LEDI_M_STOP;
            end else if (rd && nxt == 3'd2) begin
              sh_r <= byte_at(nxt);
              st_r <= LEDI_M_START;
            end else begin
              sh_r <= byte_at(nxt);
              rx_r <= rd && (nxt >= 3'd3);
            end
          end
        end
        LEDI_M_STOP: begin
          if (q_r == 2'd3)
            st_r <= LEDI_M_IDLE;
        end
        default: st_r <= LEDI_M_IDLE;
      endcase
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      en_n_r    <= 1'b1;
    end else begin
      en_n_r <= (st_r != LEDI_M_EN);
      case (st_r)
        LEDI_M_START: begin
          scl_low_r <= (q_r == 2'd0) || (q_r == 2'd3);
          sda_low_r <= q_r[1];
        end
        LEDI_M_BIT: begin
          scl_low_r <= (q_r == 2'd0) || (q_r == 2'd3);
          if (bitc_r != `LEDI_ACK_BIT)
            sda_low_r <= !rx_r && !sh_r[7];
          else
            sda_low_r <= rx_r && !last;
        end
        LEDI_M_STOP: begin
          scl_low_r <= (q_r == 2'd0);
          sda_low_r <= !q_r[1];
        end
        default: begin
          scl_low_r <= 1'b0;
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = scl_low_r;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = sda_low_r;
  assign link.en_n     = en_n_r;
endmodule

// ===== ledi_if.sv
// two-wire link with enable pin between host and led device
`timescale 1ns/1ps
interface ledi_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic en_n;
  logic scl_i;
  logic sda_i;
  // open-drain wires with pull-ups
  assign scl_i = scl_oe ? scl_o : 1'b1;
  assign sda_i = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);
  modport device (input scl_i, input sda_i, input en_n, output sda_d_o, output sda_d_oe);
  modport host (input scl_i, input sda_i, output scl_o, output scl_oe,
                output sda_h_o, output sda_h_oe, output en_n);
endinterface

// ===== ledi_pkg.sv
// types for the device and host ends of the led register port, each type used by one end
package ledi_pkg;
  typedef enum logic [2:0] {
    LEDI_D_IDLE  = 3'b000,
    LEDI_D_RX    = 3'b001,
    LEDI_D_ACK   = 3'b010,
    LEDI_D_TX    = 3'b011,
    LEDI_D_TXACK = 3'b100
  } ledi_dev_st_t;
  typedef enum logic [1:0] {
    LEDI_K_ADDR = 2'b00,
    LEDI_K_CMD  = 2'b01,
    LEDI_K_DATA = 2'b10
  } ledi_kind_t;
  typedef enum logic [2:0] {
    LEDI_M_IDLE  = 3'b000,
    LEDI_M_START = 3'b001,
    LEDI_M_BIT   = 3'b010,
    LEDI_M_STOP  = 3'b011,
    LEDI_M_EN    = 3'b100
  } ledi_mst_st_t;
endpackage

// ===== ledi_sync.sv
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module ledi_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '1
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= RST;
      q      <= RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ===== tb_i2c_led_register_port.sv
// testbench joining host and device ends over the two-wire link
`include "ledi_cfg.svh"
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module tb_i2c_led_register_port;
  import ledi_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = '0;
  logic [31:0] hwdata = '0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [6:0]  led_drive;
  logic        shutdown;
  logic        sd_seen = 1'b0;
  logic [31:0] st;
  logic [7:0]  v;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  ledi_if link();
  ledi_host #(.QTR_CYC(8), .EN_HOLD(60)) i_ledi_host (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link));
  ledi_device #(.EN_CYC(40)) i_ledi_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .led_drive(led_drive), .shutdown(shutdown));
  ledi_chk #(.EN_CYC(40)) i_ledi_chk (.hclk(hclk), .hresetn(hresetn), .scl_i(link.scl_i),
    .sda_i(link.sda_i), .sda_d_oe(link.sda_d_oe), .en_n(link.en_n),
    .led_drive(led_drive), .shutdown(shutdown));
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (shutdown === 1'b1) sd_seen <= 1'b1;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ****************************************
  // bus tasks and helpers
  // ****************************************
  task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  function automatic logic [31:0] mk(input logic [7:0] s, d0, d1, input logic [1:0] nb,
                                     input logic rd);
    mk = {5'h0, rd, nb, d1, d0, s};
  endfunction
  task automatic run(input logic [31:0] c);
    ahb(1'b1, `LEDI_A_CMD, c, st);
    do ahb(1'b0, `LEDI_A_STAT, 32'h0, st); while (st[0] !== 1'b0);
  endtask
  task automatic rdreg(input logic [3:0] i, output logic [7:0] r);
    run(mk({4'h0, i}, 8'h00, 8'h00, 2'h1, 1'b1));
    r = st[15:8];
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("led", 7'h00, led_drive)
    ahb(1'b0, `LEDI_A_SADDR, 32'h0, st);
    `CHK("saddr", 32'h45, st)
    rdreg(4'h0, v); `CHK("plane_a", 8'h00, v)
    rdreg(4'h3, v); `CHK("time", 8'h44, v)
    ahb(1'b0, 32'h0c, 32'h0, st); `CHK("unmapped", 32'h0, st)
    $display("test reset done");
  endtask
  task automatic t_auto();
    run(mk(8'h10, 8'h0f, 8'h33, 2'h2, 1'b0)); `CHK("nack", 1'b0, st[1])
    run(mk(8'h02, 8'h70, 8'h00, 2'h1, 1'b0));
    `CHK("led", 7'h73, led_drive)
    rdreg(4'h1, v); `CHK("plane_b", 8'h33, v)
    run(mk(8'h01, 8'h11, 8'h22, 2'h2, 1'b0));
    run(mk(8'h02, 8'h00, 8'h00, 2'h0, 1'b0)); `CHK("nack", 1'b0, st[1])
    rdreg(4'h1, v); `CHK("plane_b", 8'h22, v)
    rdreg(4'h2, v); `CHK("plane_c", 8'h70, v)
    run(mk(8'h1a, 8'haa, 8'h05, 2'h2, 1'b0));
    rdreg(4'h0, v); `CHK("plane_a", 8'h05, v)
    `CHK("led", 7'h72, led_drive)
    $display("test write modes done");
  endtask
  task automatic t_addr();
    ahb(1'b1, `LEDI_A_SADDR, 32'h12, st);
    run(mk(8'h00, 8'hff, 8'h00, 2'h1, 1'b0)); `CHK("nack", 1'b1, st[1])
    `CHK("led", 7'h72, led_drive)
    ahb(1'b1, `LEDI_A_SADDR, 32'h45, st);
    rdreg(4'h0, v); `CHK("plane_a", 8'h05, v)
    $display("test foreign address done");
  endtask
  task automatic t_enable();
    run(32'h1 << `LEDI_CMD_EN_BIT);
    for (int i = 0; i < 20 && shutdown !== 1'b0; i++) @(posedge hclk);
    `CHK("shutdown_seen", 1'b1, sd_seen)
    `CHK("shutdown", 1'b0, shutdown)
    `CHK("led", 7'h00, led_drive)
    rdreg(4'h0, v); `CHK("plane_a", 8'h00, v)
    rdreg(4'h2, v); `CHK("plane_c", 8'h00, v)
    $display("test enable reset done");
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_auto();
    t_addr();
    t_enable();
    give_verdict();
  end
endmodule
